// File: hdl/fskdft_pkg.sv
// Shared constants and types for the FSK divider select and error estimate block
package fskdft_pkg;

	// ==================================================================
	// Register byte offsets on the AXI4-Lite slave
	localparam int          ADDR_W       = 8;
	localparam logic [7:0]  CTRL_OFF     = 8'h00;
	localparam logic [7:0]  ZERO_DIV_OFF = 8'h04;
	localparam logic [7:0]  ONE_DIV_OFF  = 8'h08;
	localparam logic [7:0]  FEE_OFF      = 8'h0C;
	localparam logic [7:0]  TRIM_OFF     = 8'h10;

	// ==================================================================
	// Field positions
	localparam int CTRL_TX_BIT    = 0;
	localparam int CTRL_MODE_LSB  = 1;
	localparam int CTRL_LEN_LSB   = 3;
	localparam int CTRL_START_BIT = 5;
	localparam int CTRL_W         = 5;
	localparam int DIV_M_LSB      = 0;
	localparam int DIV_N_LSB      = 8;
	localparam int DIV_A_LSB      = 16;
	localparam int FEE_BUSY_BIT   = 8;
	localparam int FEE_DONE_BIT   = 9;

	// ==================================================================
	// Values after reset
	localparam logic [4:0]  CTRL_RESET = 5'h00;
	localparam logic [7:0]  DIV_RESET  = 8'h00;
	localparam logic [7:0]  TRIM_RESET = 8'h00;
	localparam logic [7:0]  FEE_RESET  = 8'h00;

	// ==================================================================
	// Symbol counts per measurement length code
	localparam logic [6:0]  MEAS_LEN_0 = 7'd8;
	localparam logic [6:0]  MEAS_LEN_1 = 7'd16;
	localparam logic [6:0]  MEAS_LEN_2 = 7'd32;
	localparam logic [6:0]  MEAS_LEN_3 = 7'd65;

	localparam logic [1:0]  RESP_OKAY   = 2'b00;
	localparam logic [1:0]  RESP_SLVERR = 2'b10;

	typedef enum logic [1:0] {
		COUNT_OFF  = 2'b00,
		COUNT_UP   = 2'b01,
		COUNT_DN   = 2'b10,
		COUNT_UPDN = 2'b11
	} fskdft_count_mode_type;

	typedef enum logic [1:0] {
		MEAS_IDLE = 2'b00,
		MEAS_RUN  = 2'b01,
		MEAS_DONE = 2'b11
	} fskdft_meas_state_type;

	function automatic logic [6:0] fskdft_meas_len(input logic [1:0] code);
		case (code)
			2'b00:   fskdft_meas_len = MEAS_LEN_0;
			2'b01:   fskdft_meas_len = MEAS_LEN_1;
			2'b10:   fskdft_meas_len = MEAS_LEN_2;
			default: fskdft_meas_len = MEAS_LEN_3;
		endcase
	endfunction

endpackage

// File: hdl/fskdft_divider_select.sv
// Picks the zero or one divider set from the synchronised transmit bit
module fskdft_divider_select #(
	parameter int DIV_W = 8
) (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic             tx_mode,
	input  wire logic             data_pin_in,
	input  wire logic [DIV_W-1:0] zero_set_divider_m,
	input  wire logic [DIV_W-1:0] zero_set_divider_n,
	input  wire logic [DIV_W-1:0] zero_set_divider_a,
	input  wire logic [DIV_W-1:0] one_set_divider_m,
	input  wire logic [DIV_W-1:0] one_set_divider_n,
	input  wire logic [DIV_W-1:0] one_set_divider_a,
	output logic                  tx_bit,
	output logic      [DIV_W-1:0] synth_divider_m,
	output logic      [DIV_W-1:0] synth_divider_n,
	output logic      [DIV_W-1:0] synth_divider_a
);
	import fskdft_pkg::*;

	logic             sync_first;
	logic             next_m_sel;
	logic [DIV_W-1:0] next_m;
	logic [DIV_W-1:0] next_n;
	logic [DIV_W-1:0] next_a;

	// ==================================================================
	// Selection
	// Receive keeps the zero set so the LO stays on a fixed channel
	always_comb begin
		next_m_sel = tx_mode & tx_bit;
		next_m = next_m_sel ? one_set_divider_m : zero_set_divider_m;
		next_n = next_m_sel ? one_set_divider_n : zero_set_divider_n;
		next_a = next_m_sel ? one_set_divider_a : zero_set_divider_a;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync_first      <= 1'b0;
			tx_bit          <= 1'b0;
			synth_divider_m <= '0;
			synth_divider_n <= '0;
			synth_divider_a <= '0;
		end else begin
			sync_first      <= data_pin_in;
			tx_bit          <= sync_first;
			synth_divider_m <= next_m;
			synth_divider_n <= next_n;
			synth_divider_a <= next_a;
		end
	end

	// ==================================================================
	// Checks
	zero_set_used_a: assert property (@(posedge aclk) disable iff (!aresetn)
		tx_mode && !tx_bit |=> synth_divider_m == $past(zero_set_divider_m)
			&& synth_divider_n == $past(zero_set_divider_n)
			&& synth_divider_a == $past(zero_set_divider_a))
		else $error("zero bit did not select zero divider set");
	one_set_used_a: assert property (@(posedge aclk) disable iff (!aresetn)
		tx_mode && tx_bit |=> synth_divider_m == $past(one_set_divider_m)
			&& synth_divider_n == $past(one_set_divider_n)
			&& synth_divider_a == $past(one_set_divider_a))
		else $error("one bit did not select one divider set");
	pin_to_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
		tx_mode [*4] ##0 data_pin_in [*4] ##1 tx_mode |-> ##1
			synth_divider_m == $past(one_set_divider_m))
		else $error("steady one on pin did not reach divider set");
	bit_one_c: cover property (@(posedge aclk) disable iff (!aresetn) tx_mode && tx_bit);
endmodule

// File: hdl/fskdft_error_counter.sv
// Wrapping signed counter of demodulator up and down pulses over a symbol window
module fskdft_error_counter (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       start,
	input  wire logic [1:0] error_count_mode_field,
	input  wire logic [1:0] meas_length_field,
	input  wire logic       symbol_strobe,
	input  wire logic       up_pulse,
	input  wire logic       dn_pulse,
	output logic      [7:0] freq_error_estimate,
	output logic            busy,
	output logic            done
);
	import fskdft_pkg::*;

	fskdft_meas_state_type state;
	fskdft_meas_state_type next_state;
	fskdft_count_mode_type mode_q;
	fskdft_count_mode_type next_mode_q;
	logic [1:0]            len_q;
	logic [1:0]            next_len_q;
	logic [6:0]            sym_cnt;
	logic [6:0]            next_sym_cnt;
	logic [6:0]            target;
	logic [7:0]            next_est;

	assign target = 7'(fskdft_meas_len(len_q) - 7'd1);
	assign busy   = (state == MEAS_RUN);
	assign done   = (state == MEAS_DONE);

	// ==================================================================
	// Measurement sequence
	always_comb begin
		next_state   = state;
		next_mode_q  = mode_q;
		next_len_q   = len_q;
		next_sym_cnt = sym_cnt;
		next_est     = freq_error_estimate;
		case (state)
			MEAS_RUN: begin
				// Eight bits modulo 256, no saturation and no overflow flag
				case (mode_q)
					COUNT_UP: if (up_pulse) next_est = 8'(freq_error_estimate + 8'h01);
					COUNT_DN: if (dn_pulse) next_est = 8'(freq_error_estimate - 8'h01);
					COUNT_UPDN: begin
						if (up_pulse && !dn_pulse) next_est = 8'(freq_error_estimate + 8'h01);
						if (dn_pulse && !up_pulse) next_est = 8'(freq_error_estimate - 8'h01);
					end
					default: next_est = freq_error_estimate;
				endcase
				if (symbol_strobe) begin
					if (sym_cnt == target) begin
						next_state = MEAS_DONE;
					end else begin
						next_sym_cnt = 7'(sym_cnt + 7'd1);
					end
				end
			end
			MEAS_IDLE, MEAS_DONE: next_state = state;
			default: next_state = MEAS_IDLE;
		endcase
		// Restart wins over any pulse in the same cycle
		if (start && error_count_mode_field != COUNT_OFF) begin
			next_state   = MEAS_RUN;
			next_mode_q  = fskdft_count_mode_type'(error_count_mode_field);
			next_len_q   = meas_length_field;
			next_sym_cnt = 7'd0;
			next_est     = FEE_RESET;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state               <= MEAS_IDLE;
			mode_q              <= COUNT_OFF;
			len_q               <= 2'b00;
			sym_cnt             <= 7'd0;
			freq_error_estimate <= FEE_RESET;
		end else begin
			state               <= next_state;
			mode_q              <= next_mode_q;
			len_q               <= next_len_q;
			sym_cnt             <= next_sym_cnt;
			freq_error_estimate <= next_est;
		end
	end

	// ==================================================================
	// Checks
	wrap_low_end_a: assert property (@(posedge aclk) disable iff (!aresetn)
		busy && !start && mode_q != COUNT_UP && dn_pulse && !up_pulse
			&& freq_error_estimate == 8'h80 |=> freq_error_estimate == 8'h7F)
		else $error("counter did not wrap from -128 to +127");
	wrap_high_end_a: assert property (@(posedge aclk) disable iff (!aresetn)
		busy && !start && mode_q != COUNT_DN && up_pulse && !dn_pulse
			&& freq_error_estimate == 8'h7F |=> freq_error_estimate == 8'h80)
		else $error("counter did not wrap from +127 to -128");
	updn_count_a: assert property (@(posedge aclk) disable iff (!aresetn)
		busy && !start && mode_q == COUNT_UPDN && dn_pulse && !up_pulse
			|=> freq_error_estimate == 8'($past(freq_error_estimate) - 8'h01))
		else $error("down pulse did not decrement estimate");
	window_end_a: assert property (@(posedge aclk) disable iff (!aresetn)
		busy && !start && symbol_strobe && sym_cnt == target |=> done ##1 done || $past(start))
		else $error("measurement window did not end on last symbol");
	start_clears_a: assert property (@(posedge aclk) disable iff (!aresetn)
		start && error_count_mode_field != COUNT_OFF |=> busy && freq_error_estimate == 8'h00)
		else $error("start did not clear estimate");
	wrap_c: cover property (@(posedge aclk) disable iff (!aresetn)
		busy && freq_error_estimate == 8'h80 ##1 freq_error_estimate == 8'h7F);
	long_window_c: cover property (@(posedge aclk) disable iff (!aresetn)
		busy && len_q == 2'b11 ##1 done);
endmodule

// File: hdl/fskdft_top.sv
// Top of the FSK divider select and frequency error estimate block with AXI4-Lite registers
//
// Chosen here: the AXI4-Lite register port and the placing of the registers.
module fskdft_top #(
	parameter int DIV_W = 8
) (
	input  wire logic                         aclk,
	input  wire logic                         aresetn,
	input  wire logic [fskdft_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                         s_axi_awvalid,
	output logic                              s_axi_awready,
	input  wire logic [31:0]                  s_axi_wdata,
	input  wire logic [3:0]                   s_axi_wstrb,
	input  wire logic                         s_axi_wvalid,
	output logic                              s_axi_wready,
	output logic      [1:0]                   s_axi_bresp,
	output logic                              s_axi_bvalid,
	input  wire logic                         s_axi_bready,
	input  wire logic [fskdft_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                         s_axi_arvalid,
	output logic                              s_axi_arready,
	output logic      [31:0]                  s_axi_rdata,
	output logic      [1:0]                   s_axi_rresp,
	output logic                              s_axi_rvalid,
	input  wire logic                         s_axi_rready,
	input  wire logic                         serial_data_pin_i,
	output logic                              serial_data_pin_o,
	output logic                              serial_data_pin_oe,
	input  wire logic                         rx_data_bit,
	input  wire logic                         demod_up_pulse,
	input  wire logic                         demod_dn_pulse,
	input  wire logic                         symbol_strobe,
	output logic      [DIV_W-1:0]             synth_divider_m,
	output logic      [DIV_W-1:0]             synth_divider_n,
	output logic      [DIV_W-1:0]             synth_divider_a,
	output logic      [7:0]                   crystal_osc_trim,
	output logic                              tx_bit
);
	import fskdft_pkg::*;

	// ==================================================================
	// Register and bus state
	logic [CTRL_W-1:0] ctrl;
	logic [CTRL_W-1:0] next_ctrl;
	logic [23:0]       zero_div;
	logic [23:0]       next_zero_div;
	logic [23:0]       one_div;
	logic [23:0]       next_one_div;
	logic [7:0]        trim;
	logic [7:0]        next_trim;
	logic              start;
	logic              next_start;
	logic              aw_held;
	logic              next_aw_held;
	logic [ADDR_W-1:0] aw_addr;
	logic [ADDR_W-1:0] next_aw_addr;
	logic              w_held;
	logic              next_w_held;
	logic [31:0]       w_data;
	logic [31:0]       next_w_data;
	logic [3:0]        w_strb;
	logic [3:0]        next_w_strb;
	logic              next_bvalid;
	logic [1:0]        next_bresp;
	logic              next_rvalid;
	logic [31:0]       next_rdata;
	logic [1:0]        next_rresp;
	logic              wr_fire;
	logic [31:0]       merged;
	logic [7:0]        fee_value;
	logic              fee_busy;
	logic              fee_done;
	logic              rx_out;
	logic              next_rx_out;

	function automatic logic [31:0] merge_strb(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) res[i*8 +: 8] = data[i*8 +: 8];
		end
		return res;
	endfunction

	function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
		logic [ADDR_W-1:0] word;
		word = {addr[ADDR_W-1:2], 2'b00};
		return word == CTRL_OFF || word == ZERO_DIV_OFF || word == ONE_DIV_OFF
			|| word == FEE_OFF || word == TRIM_OFF;
	endfunction

	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_fire       = aw_held && w_held && !s_axi_bvalid;

	// ==================================================================
	// Write path
	always_comb begin
		next_aw_held  = aw_held;
		next_aw_addr  = aw_addr;
		next_w_held   = w_held;
		next_w_data   = w_data;
		next_w_strb   = w_strb;
		next_bvalid   = s_axi_bvalid;
		next_bresp    = s_axi_bresp;
		next_ctrl     = ctrl;
		next_zero_div = zero_div;
		next_one_div  = one_div;
		next_trim     = trim;
		next_start    = 1'b0;
		merged        = 32'h0000_0000;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		if (s_axi_bvalid && s_axi_bready) next_bvalid = 1'b0;
		if (wr_fire) begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = is_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
			case ({aw_addr[ADDR_W-1:2], 2'b00})
				CTRL_OFF: begin
					merged     = merge_strb({27'h0, ctrl}, w_data, w_strb);
					next_ctrl  = merged[CTRL_W-1:0];
					next_start = merged[CTRL_START_BIT];
				end
				ZERO_DIV_OFF: begin
					merged        = merge_strb({8'h00, zero_div}, w_data, w_strb);
					next_zero_div = merged[23:0];
				end
				ONE_DIV_OFF: begin
					merged       = merge_strb({8'h00, one_div}, w_data, w_strb);
					next_one_div = merged[23:0];
				end
				TRIM_OFF: begin
					merged    = merge_strb({24'h0, trim}, w_data, w_strb);
					next_trim = merged[7:0];
				end
				default: merged = 32'h0000_0000;
			endcase
		end
	end

	// ==================================================================
	// Read path
	always_comb begin
		next_rvalid = s_axi_rvalid;
		next_rdata  = s_axi_rdata;
		next_rresp  = s_axi_rresp;
		if (s_axi_rvalid && s_axi_rready) next_rvalid = 1'b0;
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rresp  = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			case ({s_axi_araddr[ADDR_W-1:2], 2'b00})
				CTRL_OFF:     next_rdata = {27'h0, ctrl};
				ZERO_DIV_OFF: next_rdata = {8'h00, zero_div};
				ONE_DIV_OFF:  next_rdata = {8'h00, one_div};
				FEE_OFF:      next_rdata = {22'h0, fee_done, fee_busy, fee_value};
				TRIM_OFF:     next_rdata = {24'h0, trim};
				default:      next_rdata = 32'h0000_0000;
			endcase
		end
	end

	// ==================================================================
	// Serial data pin direction
	always_comb begin
		next_rx_out = rx_data_bit;
	end

	// Driven only while receiving, so the host owns the wire in transmit
	assign serial_data_pin_oe = !ctrl[CTRL_TX_BIT];
	assign serial_data_pin_o  = rx_out;
	assign crystal_osc_trim   = trim;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl         <= CTRL_RESET;
			zero_div     <= {3{DIV_RESET}};
			one_div      <= {3{DIV_RESET}};
			trim         <= TRIM_RESET;
			start        <= 1'b0;
			aw_held      <= 1'b0;
			aw_addr      <= '0;
			w_held       <= 1'b0;
			w_data       <= 32'h0000_0000;
			w_strb       <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= RESP_OKAY;
			rx_out       <= 1'b0;
		end else begin
			ctrl         <= next_ctrl;
			zero_div     <= next_zero_div;
			one_div      <= next_one_div;
			trim         <= next_trim;
			start        <= next_start;
			aw_held      <= next_aw_held;
			aw_addr      <= next_aw_addr;
			w_held       <= next_w_held;
			w_data       <= next_w_data;
			w_strb       <= next_w_strb;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp  <= next_bresp;
			s_axi_rvalid <= next_rvalid;
			s_axi_rdata  <= next_rdata;
			s_axi_rresp  <= next_rresp;
			rx_out       <= next_rx_out;
		end
	end

	// ==================================================================
	// Submodules
	fskdft_divider_select #(
		.DIV_W (DIV_W)
	) u_divider_select (
		.aclk               (aclk),
		.aresetn            (aresetn),
		.tx_mode            (ctrl[CTRL_TX_BIT]),
		.data_pin_in        (serial_data_pin_i),
		.zero_set_divider_m (zero_div[DIV_M_LSB +: DIV_W]),
		.zero_set_divider_n (zero_div[DIV_N_LSB +: DIV_W]),
		.zero_set_divider_a (zero_div[DIV_A_LSB +: DIV_W]),
		.one_set_divider_m  (one_div[DIV_M_LSB +: DIV_W]),
		.one_set_divider_n  (one_div[DIV_N_LSB +: DIV_W]),
		.one_set_divider_a  (one_div[DIV_A_LSB +: DIV_W]),
		.tx_bit             (tx_bit),
		.synth_divider_m    (synth_divider_m),
		.synth_divider_n    (synth_divider_n),
		.synth_divider_a    (synth_divider_a)
	);

	fskdft_error_counter u_error_counter (
		.aclk                   (aclk),
		.aresetn                (aresetn),
		.start                  (start),
		.error_count_mode_field (ctrl[CTRL_MODE_LSB +: 2]),
		.meas_length_field      (ctrl[CTRL_LEN_LSB +: 2]),
		.symbol_strobe          (symbol_strobe),
		.up_pulse               (demod_up_pulse),
		.dn_pulse               (demod_dn_pulse),
		.freq_error_estimate    (fee_value),
		.busy                   (fee_busy),
		.done                   (fee_done)
	);

	// ==================================================================
	// Checks
	pin_direction_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ctrl[CTRL_TX_BIT] |-> !serial_data_pin_oe ##0 $past(rx_data_bit) == serial_data_pin_o)
		else $error("data pin driven while transmitting");
	fee_readback_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready && s_axi_araddr[ADDR_W-1:2] == FEE_OFF[ADDR_W-1:2]
			|=> s_axi_rvalid && s_axi_rdata[7:0] == $past(fee_value))
		else $error("estimate register read returned wrong value");
	write_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_fire |=> s_axi_bvalid && !aw_held && !w_held)
		else $error("write response missing after address and data");
	fee_read_c: cover property (@(posedge aclk) disable iff (!aresetn)
		s_axi_rvalid && s_axi_rready && fee_done);
	tx_write_c: cover property (@(posedge aclk) disable iff (!aresetn)
		wr_fire && aw_addr == CTRL_OFF && w_data[CTRL_TX_BIT]);
endmodule

// File: bench/fskdft_host_model.sv
// Host side model that drives transmit bits and resolves the data pin
module fskdft_host_model (
	input  wire logic send_bit,
	input  wire logic pin_o,
	input  wire logic pin_oe,
	output logic      pin
);
	timeunit 1ns;
	timeprecision 1ps;
	// ====
	// Pin level
	// Host only drives while the device has let go
	assign pin = pin_oe ? pin_o : send_bit;
endmodule

// File: bench/fskdft_top_tb_top.sv
// Self-checking bench for the FSK divider select and error estimate block
module fskdft_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import fskdft_pkg::*;
	logic        aclk = 1'h0;
	logic        aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
	logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, pin, send_bit;
	logic        serial_data_pin_o, serial_data_pin_oe, rx_data_bit, tx_bit;
	logic        demod_up_pulse, demod_dn_pulse, symbol_strobe;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, crystal_osc_trim;
	logic [7:0]  synth_divider_m, synth_divider_n, synth_divider_a;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	int          failures, cmp_count;
	always #2.5 aclk = ~aclk;
	fskdft_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.serial_data_pin_i(pin), .serial_data_pin_o, .serial_data_pin_oe, .rx_data_bit,
		.demod_up_pulse, .demod_dn_pulse, .symbol_strobe, .synth_divider_m,
		.synth_divider_n, .synth_divider_a, .crystal_osc_trim, .tx_bit);
	fskdft_host_model host_u (.send_bit(send_bit), .pin_o(serial_data_pin_o),
		.pin_oe(serial_data_pin_oe), .pin(pin));
	// ====
	// Shared tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish;
		if (failures == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask
	// Handshakes are judged at the rising edge; a spare edge after each call
	// keeps the next call from assigning a signal twice in one time step
	task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		logic tk;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'h0;
			tk = s_axi_bvalid;
			rs = s_axi_bresp;
		end while (!tk);
		s_axi_bready <= 1'h0;
		@(posedge aclk);
	endtask
	task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		logic k;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'h0;
			k = s_axi_rvalid;
			v = s_axi_rdata;
			rs = s_axi_rresp;
		end while (!k);
		s_axi_rready <= 1'h0;
		@(posedge aclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic [1:0] rs;
		axw(a, v, rs);
		chk(32'(rs), 32'(RESP_OKAY));
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] v;
		logic [1:0]  rs;
		axr(a, v, rs);
		chk(v, e);
	endtask
	// Pulses run a few cycles before the strobes so the window edge is exact
	task automatic meas(input logic [31:0] c, input int n, nu, nd, ns);
		wr(CTRL_OFF, c);
		tick(2);
		for (int i = 0; i < n; i++) begin
			demod_up_pulse <= (i < nu);
			demod_dn_pulse <= (i < nd);
			symbol_strobe <= (i >= n - ns);
			tick(1);
		end
		demod_up_pulse <= 1'h0;
		demod_dn_pulse <= 1'h0;
		symbol_strobe <= 1'h0;
	endtask
	// ====
	// Scenarios
	task automatic reset_and_map;
		rdc(CTRL_OFF, 32'h0);
		rdc(FEE_OFF, 32'h0);
		rdc(TRIM_OFF, 32'h0);
		axr(8'h14, d, r);
		chk(32'(r), 32'(RESP_SLVERR));
		axw(8'h14, 32'h1, r);
		chk(32'(r), 32'(RESP_SLVERR));
	endtask
	task automatic divider_sets;
		wr(ZERO_DIV_OFF, 32'h0003_0201);
		wr(ONE_DIV_OFF, 32'h0006_0504);
		wr(CTRL_OFF, 32'h1);
		chk(32'(serial_data_pin_oe), 32'h0);
		tick(4);
		chk({8'h00, synth_divider_a, synth_divider_n, synth_divider_m}, 32'h030201);
		chk(32'(tx_bit), 32'h0);
		send_bit <= 1'h1;
		tick(4);
		chk({8'h00, synth_divider_a, synth_divider_n, synth_divider_m}, 32'h060504);
		chk(32'(tx_bit), 32'h1);
	endtask
	task automatic receive_pin;
		wr(CTRL_OFF, 32'h0);
		rx_data_bit <= 1'h1;
		tick(2);
		chk(32'({serial_data_pin_oe, pin}), 32'h3);
	endtask
	task automatic wrap_counts;
		meas(32'h3A, 130, 130, 130, 65);
		rdc(FEE_OFF, 32'h282);
		meas(32'h3C, 130, 130, 130, 65);
		rdc(FEE_OFF, 32'h27E);
	endtask
	task automatic window_lengths;
		meas(32'h26, 10, 10, 7, 7);
		rdc(FEE_OFF, 32'h103);
		symbol_strobe <= 1'h1;
		tick(1);
		symbol_strobe <= 1'h0;
		rdc(FEE_OFF, 32'h203);
		wr(CTRL_OFF, 32'h20);
		rdc(FEE_OFF, 32'h203);
	endtask
	// Host moves the trim against the sign of the estimate, counts kept in range
	task automatic trim_tune;
		wr(TRIM_OFF, 32'h80);
		meas(32'h2E, 20, 20, 16, 16);
		rdc(FEE_OFF, 32'h204);
		wr(TRIM_OFF, 32'h7F);
		chk(32'(crystal_osc_trim), 32'h7F);
		rdc(TRIM_OFF, 32'h7F);
		meas(32'h36, 40, 0, 8, 32);
		rdc(FEE_OFF, 32'h2F8);
		wr(TRIM_OFF, 32'h80);
		chk(32'(crystal_osc_trim), 32'h80);
		meas(32'h26, 10, 10, 10, 8);
		rdc(FEE_OFF, 32'h200);
		rdc(TRIM_OFF, 32'h80);
	endtask
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, send_bit, rx_data_bit} = '0;
		{demod_up_pulse, demod_dn_pulse, symbol_strobe} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		tick(10);
		aresetn <= 1'h1;
		reset_and_map;
		divider_sets;
		receive_pin;
		wrap_counts;
		window_lengths;
		trim_tune;
		tally_and_finish;
	end
	initial begin
		#100000;
		failures++;
		tally_and_finish;
	end
endmodule
